// ===== common/spue_defs.svh
// Purpose: shared constants of the pack/unpack/extract datapath
// Assumes: included by bare name from the package and the top-level design file
// Notes:   opcode values, widths, reset values and shift limits
`ifndef SPUE_DEFS_SVH
`define SPUE_DEFS_SVH

// operation codes on the op_code port
`define SPUE_OP_PACK_DW_W   4'h0
`define SPUE_OP_PACK_W_UB   4'h1
`define SPUE_OP_UNPK_LO_W   4'h2
`define SPUE_OP_UNPK_HI_W   4'h3
`define SPUE_OP_UNPK_LO_DW  4'h4
`define SPUE_OP_UNPK_HI_DW  4'h5
`define SPUE_OP_SRA_DW      4'h6
`define SPUE_OP_SLL_DW      4'h7
`define SPUE_OP_AND         4'h8
`define SPUE_OP_OR          4'h9
`define SPUE_OP_EXTR_W      4'ha

// widths
`define SPUE_VEC_W          128
`define SPUE_GPR_W          32

// word saturation limits as 32-bit signed values
`define SPUE_S16_MAX        32'sh0000_7fff
`define SPUE_S16_MIN        32'shffff_8000

// largest meaningful per-doubleword shift count
`define SPUE_SHIFT_MAX      8'h1f

// reset values of the result registers
`define SPUE_RES_VEC_RST    128'h0
`define SPUE_RES_GPR_RST    32'h0

`endif

// ===== common/spue_pkg.sv
// Purpose: types and saturation helpers of the pack/unpack datapath
// Assumes: spue_defs.svh supplies the opcode values
// Notes:   referenced as spue_pkg::name, never imported
`include "spue_defs.svh"

package spue_pkg;

   // operations the datapath carries out
   typedef enum logic [3:0] {
      SPUE_PACK_DW_W  = `SPUE_OP_PACK_DW_W,
      SPUE_PACK_W_UB  = `SPUE_OP_PACK_W_UB,
      SPUE_UNPK_LO_W  = `SPUE_OP_UNPK_LO_W,
      SPUE_UNPK_HI_W  = `SPUE_OP_UNPK_HI_W,
      SPUE_UNPK_LO_DW = `SPUE_OP_UNPK_LO_DW,
      SPUE_UNPK_HI_DW = `SPUE_OP_UNPK_HI_DW,
      SPUE_SRA_DW     = `SPUE_OP_SRA_DW,
      SPUE_SLL_DW     = `SPUE_OP_SLL_DW,
      SPUE_AND        = `SPUE_OP_AND,
      SPUE_OR         = `SPUE_OP_OR,
      SPUE_EXTR_W     = `SPUE_OP_EXTR_W
   } spue_op_t;

   // signed doubleword to signed word with saturation
   function automatic logic [15:0] spue_sat_s16(input logic [31:0] v);
      if ($signed(v) > `SPUE_S16_MAX) begin
         return 16'h7fff;
      end else if ($signed(v) < `SPUE_S16_MIN) begin
         return 16'h8000;
      end
      return v[15:0];
   endfunction : spue_sat_s16

   // signed word to unsigned byte with saturation
   function automatic logic [7:0] spue_sat_u8(input logic [15:0] v);
      if (v[15]) begin
         return 8'h00;
      end else if (v[14:8] != 7'h00) begin
         return 8'hff;
      end
      return v[7:0];
   endfunction : spue_sat_u8

endpackage : spue_pkg

// ===== verilog/spue_pack.sv
// Purpose: saturating packs of one destination/source operand pair
// Assumes: operands are signed two's-complement elements
// Notes:   purely combinational; W is the operand width in bits
`timescale 1ns/100ps
`default_nettype none

module spue_pack #(
   parameter int W = 128
) (
   input  wire logic [W-1:0] dst_v,
   input  wire logic [W-1:0] src_v,
   output var  logic [W-1:0] dw_to_w,
   output var  logic [W-1:0] w_to_ub
);

   // destination elements fill the low half, source the high half
   wire logic [2*W-1:0] both_v = {src_v, dst_v};

   generate
      if (W % 64 != 0) begin : g_bad_w
         $error("spue_pack: W must be a multiple of 64");
      end
   endgenerate

   always_comb begin
      for (int i = 0; i < W / 16; i++) begin
         dw_to_w[16*i +: 16] = spue_pkg::spue_sat_s16(both_v[32*i +: 32]);
      end
   end

   always_comb begin
      for (int i = 0; i < W / 8; i++) begin
         w_to_ub[8*i +: 8] = spue_pkg::spue_sat_u8(both_v[16*i +: 16]);
      end
   end

endmodule : spue_pack

`default_nettype wire

// ===== verilog/spue_top.sv
// Purpose: packed-integer pack, unpack, shift, logic and extract unit
// Assumes: op_valid marks one operation per cycle from issue logic
// Notes:   result appears one cycle after issue, registered outputs
`timescale 1ns/100ps
`default_nettype none
`include "spue_defs.svh"

module spue_top #(
   parameter int VEC_W = `SPUE_VEC_W,
   parameter int GPR_W = `SPUE_GPR_W
) (
   input  wire logic             core_clk,
   input  wire logic             rst_b,
   input  wire logic             op_valid,
   input  wire logic [3:0]       op_code,
   input  wire logic             op_wide,
   input  wire logic [VEC_W-1:0] dst_opnd,
   input  wire logic [VEC_W-1:0] src_opnd,
   input  wire logic [7:0]       op_imm,
   output var  logic             res_valid_q,
   output var  logic [VEC_W-1:0] res_vec_q,
   output var  logic [GPR_W-1:0] res_gpr_q,
   output var  logic             res_to_gpr_q,
   output var  logic             res_illegal_q
);

   // the lane arithmetic is written for these widths only
   generate
      if (VEC_W != 128 || GPR_W != 32) begin : g_bad_par
         $error("spue_top: VEC_W must be 128 and GPR_W 32");
      end
   endgenerate

   // opcode decode
   wire logic is_pdw  = op_code == `SPUE_OP_PACK_DW_W;
   wire logic is_pub  = op_code == `SPUE_OP_PACK_W_UB;
   wire logic is_ulw  = op_code == `SPUE_OP_UNPK_LO_W;
   wire logic is_uhw  = op_code == `SPUE_OP_UNPK_HI_W;
   wire logic is_uld  = op_code == `SPUE_OP_UNPK_LO_DW;
   wire logic is_uhd  = op_code == `SPUE_OP_UNPK_HI_DW;
   wire logic is_sra  = op_code == `SPUE_OP_SRA_DW;
   wire logic is_sll  = op_code == `SPUE_OP_SLL_DW;
   wire logic is_and  = op_code == `SPUE_OP_AND;
   wire logic is_or   = op_code == `SPUE_OP_OR;
   wire logic is_ext  = op_code == `SPUE_OP_EXTR_W;
   wire logic is_ill  = op_code > `SPUE_OP_EXTR_W;

   // 64-bit forms see only the low halves of the operands
   wire logic [63:0]  dst_lo = dst_opnd[63:0];
   wire logic [63:0]  src_lo = src_opnd[63:0];

   // packs in both widths
   // two pack widths
   wire logic [127:0] pdw_128;
   wire logic [127:0] pub_128;
   wire logic [63:0]  pdw_64;
   wire logic [63:0]  pub_64;

   spue_pack #(.W(128)) u_pack_128 (
      .dst_v   (dst_opnd),
      .src_v   (src_opnd),
      .dw_to_w (pdw_128),
      .w_to_ub (pub_128)
   );

   spue_pack #(.W(64)) u_pack_64 (
      .dst_v   (dst_lo),
      .src_v   (src_lo),
      .dw_to_w (pdw_64),
      .w_to_ub (pub_64)
   );

   wire logic [127:0] ulw_128;
   wire logic [127:0] uhw_128;
   wire logic [63:0]  ulw_64;
   wire logic [63:0]  uhw_64;

   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_uw128
         assign ulw_128[32*gi +: 16]      = dst_opnd[16*gi +: 16];
         assign ulw_128[32*gi + 16 +: 16] = src_opnd[16*gi +: 16];
         assign uhw_128[32*gi +: 16]      = dst_opnd[16*(gi+4) +: 16];
         assign uhw_128[32*gi + 16 +: 16] = src_opnd[16*(gi+4) +: 16];
      end
      for (gi = 0; gi < 2; gi++) begin : g_uw64
         assign ulw_64[32*gi +: 16]      = dst_opnd[16*gi +: 16];
         assign ulw_64[32*gi + 16 +: 16] = src_opnd[16*gi +: 16];
         assign uhw_64[32*gi +: 16]      = dst_opnd[16*(gi+2) +: 16];
         assign uhw_64[32*gi + 16 +: 16] = src_opnd[16*(gi+2) +: 16];
      end
   endgenerate

   // doubleword interleave
   // wide forms pair the low two or the high two doublewords
   wire logic [127:0] uld_128 = {src_opnd[63:32], dst_opnd[63:32],
                                 src_opnd[31:0],  dst_opnd[31:0]};
   wire logic [127:0] uhd_128 = {src_opnd[127:96], dst_opnd[127:96],
                                 src_opnd[95:64],  dst_opnd[95:64]};
   wire logic [63:0]  uld_64  = {src_opnd[31:0],  dst_opnd[31:0]};
   wire logic [63:0]  uhd_64  = {src_opnd[63:32], dst_opnd[63:32]};

   // counts past 31 fill the whole doubleword
   wire logic        sh_big = op_imm > `SPUE_SHIFT_MAX;
   wire logic [4:0]  sh_amt = op_imm[4:0];

   wire logic [127:0] sra_128;
   wire logic [127:0] sll_128;

   generate
      for (gi = 0; gi < 4; gi++) begin : g_shift
         wire logic [31:0] dw = dst_opnd[32*gi +: 32];
         assign sra_128[32*gi +: 32] = sh_big ? {32{dw[31]}}
                                              : 32'($signed(dw) >>> sh_amt);
         assign sll_128[32*gi +: 32] = sh_big ? 32'h0000_0000
                                              : dw << sh_amt;
      end
   endgenerate

   wire logic [127:0] and_128 = dst_opnd & src_opnd;
   wire logic [127:0] or_128  = dst_opnd | src_opnd;

   wire logic [15:0] ext_w   = dst_lo[{op_imm[1:0], 4'h0} +: 16];
   wire logic [31:0] ext_gpr = {16'h0000, ext_w};

   // full-width results, then narrowing for 64-bit forms
   wire logic [127:0] wide_res =
      is_pdw ? pdw_128 :
      is_pub ? pub_128 :
      is_ulw ? ulw_128 :
      is_uhw ? uhw_128 :
      is_uld ? uld_128 :
      is_uhd ? uhd_128 :
      is_sra ? sra_128 :
      is_sll ? sll_128 :
      is_and ? and_128 :
      is_or  ? or_128  : 128'h0;

   wire logic [63:0] narrow_res =
      is_pdw ? pdw_64 :
      is_pub ? pub_64 :
      is_ulw ? ulw_64 :
      is_uhw ? uhw_64 :
      is_uld ? uld_64 :
      is_uhd ? uhd_64 : wide_res[63:0];

   wire logic [127:0] vec_d = op_wide ? wide_res : {64'h0, narrow_res};

   // result registers
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         res_valid_q   <= 1'b0;
         res_vec_q     <= `SPUE_RES_VEC_RST;
         res_gpr_q     <= `SPUE_RES_GPR_RST;
         res_to_gpr_q  <= 1'b0;
         res_illegal_q <= 1'b0;
      end else begin
         res_valid_q   <= op_valid;
         res_illegal_q <= op_valid && is_ill;
         if (op_valid) begin
            res_to_gpr_q <= is_ext;
            res_vec_q    <= (is_ext || is_ill) ? res_vec_q : vec_d;
            res_gpr_q    <= is_ext ? ext_gpr : res_gpr_q;
         end
      end
   end

   // checks on the registered results
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!rst_b);

   pack_word_sat_a: assert property (
      op_valid && is_pdw && !op_wide && !dst_opnd[31] && dst_opnd[30:15] != 0
      |=> res_vec_q[15:0] == 16'h7fff && res_vec_q[127:64] == 64'h0)
      else $error("64-bit word pack did not saturate high");

   pack_wide_a: assert property (
      op_valid && is_pdw && op_wide
      |=> res_vec_q[127:112]
          == spue_pkg::spue_sat_s16($past(src_opnd[127:96])))
      else $error("128-bit pack top word wrong");

   pack_signed_a: assert property (
      op_valid && is_pub && dst_opnd[15]
      |=> res_vec_q[7:0] == 8'h00)
      else $error("negative word did not pack to zero");

   pack_byte_a: assert property (
      op_valid && is_pub && !op_wide
      |=> res_vec_q[63:56] == spue_pkg::spue_sat_u8($past(src_opnd[63:48]))
          && res_vec_q[127:64] == 64'h0)
      else $error("byte pack top byte wrong");

   pack_clamp_a: assert property (
      op_valid && is_pdw && dst_opnd[31] && dst_opnd[30:15] != 16'hffff
      |=> res_vec_q[15:0] == 16'h8000)
      else $error("word pack did not clamp low");

   unpk_low_w_a: assert property (
      op_valid && is_ulw
      |=> res_vec_q[31:0] == {$past(src_opnd[15:0]), $past(dst_opnd[15:0])})
      else $error("low word unpack misplaced");

   unpk_high_w_a: assert property (
      op_valid && is_uhw && !op_wide
      |=> res_vec_q[63:48] == $past(src_opnd[63:48]))
      else $error("high word unpack misplaced");

   unpk_low_dw_a: assert property (
      op_valid && is_uld && !op_wide
      |=> res_vec_q[63:0] == {$past(src_opnd[31:0]), $past(dst_opnd[31:0])})
      else $error("low dword unpack wrong");

   unpk_high_dw_a: assert property (
      op_valid && is_uhd && !op_wide
      |=> res_vec_q[63:0] == {$past(src_opnd[63:32]), $past(dst_opnd[63:32])})
      else $error("high dword unpack wrong");

   shift_right_a: assert property (
      op_valid && is_sra && op_imm == 8'h10
      |=> res_vec_q[31:0] == {{16{$past(dst_opnd[31])}}, $past(dst_opnd[31:16])})
      else $error("arithmetic shift by 16 wrong");

   shift_left_a: assert property (
      op_valid && is_sll && op_imm == 8'h10
      |=> res_vec_q[63:32] == {$past(dst_opnd[47:32]), 16'h0000})
      else $error("left shift by 16 wrong");

   logic_and_a: assert property (
      op_valid && is_and && !op_wide
      |=> res_vec_q[63:0] == ($past(dst_opnd[63:0]) & $past(src_opnd[63:0])))
      else $error("AND result wrong");

   logic_or_a: assert property (
      op_valid && is_or && op_wide
      |=> res_vec_q == ($past(dst_opnd) | $past(src_opnd)))
      else $error("OR result wrong");

   extract_word_a: assert property (
      op_valid && is_ext && op_imm[1:0] == 2'h3
      |=> res_to_gpr_q && res_gpr_q[15:0] == $past(dst_opnd[63:48]))
      else $error("extracted word wrong");

   extract_zero_a: assert property (
      res_valid_q && res_to_gpr_q |-> res_gpr_q[31:16] == 16'h0000)
      else $error("extract upper half not zero");

   unpk_wide_w_a: assert property (
      op_valid && is_uhw && op_wide
      |=> res_vec_q[127:96] == {$past(src_opnd[127:112]),
                                $past(dst_opnd[127:112])})
      else $error("wide high word unpack misplaced");

   unpk_wide_lo_a: assert property (
      op_valid && is_uld && op_wide
      |=> res_vec_q[127:64] == {$past(src_opnd[63:32]),
                                $past(dst_opnd[63:32])})
      else $error("wide low dword unpack wrong");

   unpk_wide_hi_a: assert property (
      op_valid && is_uhd && op_wide
      |=> res_vec_q[63:0] == {$past(src_opnd[95:64]),
                              $past(dst_opnd[95:64])})
      else $error("wide high dword unpack wrong");

   pack_wide_byte_a: assert property (
      op_valid && is_pub && op_wide
      |=> res_vec_q[127:120]
          == spue_pkg::spue_sat_u8($past(src_opnd[127:112])))
      else $error("128-bit byte pack top byte wrong");

   narrow_clear_a: assert property (
      op_valid && !op_wide && !is_ext && !is_ill
      |=> res_vec_q[127:64] == 64'h0)
      else $error("64-bit form left upper half set");

   shift_fill_a: assert property (
      op_valid && is_sra && op_wide && op_imm > 8'h1f
      |=> res_vec_q[127:96] == {32{$past(dst_opnd[127])}})
      else $error("large arithmetic shift not sign filled");

   illegal_hold_a: assert property (
      op_valid && is_ill
      |=> res_illegal_q && !res_to_gpr_q
          && $stable(res_vec_q) && $stable(res_gpr_q))
      else $error("illegal operation changed a result");

   result_timing_a: assert property (
      op_valid |=> res_valid_q ##1 (res_valid_q == $past(op_valid)))
      else $error("result valid not one cycle after issue");

   pack_wide_c:    cover property (op_valid && is_pdw && op_wide);
   unpk_signed_c:  cover property (op_valid && is_ulw ##1 op_valid && is_sra);
   extract_c:      cover property (op_valid && is_ext ##1 res_to_gpr_q);
   illegal_c:      cover property (op_valid && is_ill ##1 res_illegal_q);

endmodule : spue_top

`default_nettype wire

// ===== test/spue_issue_model.sv
// Purpose: issue logic model that feeds operands to the datapath
// Assumes: callers sit on a falling edge of core_clk
// Notes:   idle cycles scramble operands so stale values never match
`timescale 1ns/100ps
`default_nettype none

module spue_issue_model (
   output logic         op_valid,
   output logic [3:0]   op_code,
   output logic         op_wide,
   output logic [127:0] dst_opnd,
   output logic [127:0] src_opnd,
   output logic [7:0]   op_imm
);
   // start idle with known operand values
   initial begin
      op_valid = 1'b0;
      op_code  = 4'h0;
      op_wide  = 1'b0;
      dst_opnd = 128'h0;
      src_opnd = 128'h0;
      op_imm   = 8'h00;
   end

   // present one operation for the next rising edge
   task automatic drive(input logic [3:0] c, input logic w,
                        input logic [127:0] d, input logic [127:0] s,
                        input logic [7:0] n);
      op_valid = 1'b1;
      op_code  = c;
      op_wide  = w;
      dst_opnd = d;
      src_opnd = s;
      op_imm   = n;
   endtask : drive

   // withdraw the request, operands stop holding their value
   task automatic idle();
      op_valid = 1'b0;
      dst_opnd = ~dst_opnd;
      src_opnd = ~src_opnd;
      op_imm   = ~op_imm;
   endtask : idle
endmodule : spue_issue_model
`default_nettype wire

// ===== test/spue_top_test.sv
// Purpose: self-checking bench of the pack/unpack/extract datapath
// Assumes: one cycle from issue to registered result
// Notes:   corner operands on every code, then seeded random traffic
`timescale 1ns/100ps
`default_nettype none

module spue_top_test;
   logic              core_clk;
   logic              rst_b;
   wire logic         op_valid;
   wire logic [3:0]   op_code;
   wire logic         op_wide;
   wire logic [127:0] dst_opnd;
   wire logic [127:0] src_opnd;
   wire logic [7:0]   op_imm;
   wire logic         res_valid_q;
   wire logic [127:0] res_vec_q;
   wire logic [31:0]  res_gpr_q;
   wire logic         res_to_gpr_q;
   wire logic         res_illegal_q;
   int                fails = 0;
   int                checked = 0;
   int                cycles = 0;
   int                seed;
   logic [127:0]      vexp;
   logic [31:0]       gexp;
   logic [31:0]       r;
   logic [7:0]        imms [6] = '{8'h10, 8'h1f, 8'h20, 8'hff, 8'h01, 8'h02};

   spue_issue_model spue_issue_model_inst (
      .op_valid(op_valid), .op_code(op_code), .op_wide(op_wide),
      .dst_opnd(dst_opnd), .src_opnd(src_opnd), .op_imm(op_imm));

   spue_top spue_top_inst (
      .core_clk(core_clk), .rst_b(rst_b), .op_valid(op_valid),
      .op_code(op_code), .op_wide(op_wide), .dst_opnd(dst_opnd),
      .src_opnd(src_opnd), .op_imm(op_imm), .res_valid_q(res_valid_q),
      .res_vec_q(res_vec_q), .res_gpr_q(res_gpr_q),
      .res_to_gpr_q(res_to_gpr_q), .res_illegal_q(res_illegal_q));

   // 25 MHz core clock
   initial begin
      core_clk = 1'b0;
      forever #20 core_clk = ~core_clk;
   end

   // hang guard, the run needs well under a thousand cycles
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 3000) begin
         fails++;
         results();
      end
   end

   // signed word clamp
   function automatic logic [15:0] sat16(input logic [31:0] v);
      if ($signed(v) > 32767) return 16'h7fff;
      if ($signed(v) < -32768) return 16'h8000;
      return v[15:0];
   endfunction : sat16

   // unsigned byte clamp of a signed word
   function automatic logic [7:0] satu8(input logic [15:0] v);
      if ($signed(v) < 0) return 8'h00;
      if ($signed(v) > 255) return 8'hff;
      return v[7:0];
   endfunction : satu8

   // expected vector result of one operation
   function automatic logic [127:0] exp_vec(input logic [3:0] c,
      input logic w, input logic [127:0] d, input logic [127:0] s,
      input logic [7:0] n);
      logic [127:0] v;
      int h;
      int o;
      int k;
      v = '0;
      h = w ? 4 : 2;
      o = c[0] ? h : 0;
      k = (n > 8'h1f) ? 31 : int'(n);
      case (c)
         4'h0: for (int i = 0; i < h; i++) begin
            v[16*i+:16] = sat16(d[32*i+:32]);
            v[16*(i+h)+:16] = sat16(s[32*i+:32]);
         end
         4'h1: for (int i = 0; i < 2*h; i++) begin
            v[8*i+:8] = satu8(d[16*i+:16]);
            v[8*(i+2*h)+:8] = satu8(s[16*i+:16]);
         end
         4'h2, 4'h3: for (int i = 0; i < h; i++) begin
            v[32*i+:32] = {s[16*(i+o)+:16], d[16*(i+o)+:16]};
         end
         4'h4, 4'h5: for (int i = 0; i < h/2; i++) begin
            v[64*i+:64] = {s[32*(i+o/2)+:32], d[32*(i+o/2)+:32]};
         end
         4'h6: for (int i = 0; i < h; i++) begin
            v[32*i+:32] = $signed(d[32*i+:32]) >>> k;
         end
         4'h7: for (int i = 0; i < h; i++) begin
            v[32*i+:32] = (n > 8'h1f) ? 32'h0 : d[32*i+:32] << k;
         end
         4'h8: v = d & s;
         4'h9: v = d | s;
         default: v = '0;
      endcase
      if (!w) v[127:64] = '0;
      return v;
   endfunction : exp_vec

   function automatic logic [127:0] rnd128();
      return {$random(seed), $random(seed), $random(seed), $random(seed)};
   endfunction : rnd128

   // compare tasks, one per kind of result
   task automatic chk_vec(input logic [127:0] g, input logic [127:0] e);
      checked++;
      if (g !== e) begin
         fails++;
         $display("CHECK FAILED t=%0t vec got %h exp %h", $time, g, e);
      end
   endtask : chk_vec

   task automatic chk_gpr(input logic [31:0] g, input logic [31:0] e);
      checked++;
      if (g !== e) begin
         fails++;
         $display("CHECK FAILED t=%0t gpr got %h exp %h", $time, g, e);
      end
   endtask : chk_gpr

   task automatic chk_bit(input logic g, input logic e);
      checked++;
      if (g !== e) begin
         fails++;
         $display("CHECK FAILED t=%0t flag got %b exp %b", $time, g, e);
      end
   endtask : chk_bit

   // issue one operation and check its result a cycle later
   task automatic run_op(input logic [3:0] c, input logic w,
      input logic [127:0] d, input logic [127:0] s, input logic [7:0] n);
      logic ill;
      logic ext;
      ill = (c > 4'ha);
      ext = (c == 4'ha);
      spue_issue_model_inst.drive(c, w, d, s, n);
      if (!ill && !ext) vexp = exp_vec(c, w, d, s, n);
      if (ext) gexp = {16'h0, d[16*n[1:0]+:16]};
      @(negedge core_clk);
      chk_bit(res_valid_q, 1'b1);
      chk_bit(res_illegal_q, ill);
      chk_bit(res_to_gpr_q, ext);
      chk_vec(res_vec_q, vexp);
      chk_gpr(res_gpr_q, gexp);
   endtask : run_op

   // verdict and end of run
   task automatic results();
      $display("fails=%0d checked=%0d", fails, checked);
      if (fails == 0 && checked > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : results

   // reset, corner table, random traffic, idle and second reset
   initial begin
      seed = 58500;
      vexp = '0;
      gexp = '0;
      rst_b = 1'b0;
      repeat (4) @(negedge core_clk);
      chk_vec(res_vec_q, vexp);
      rst_b = 1'b1;
      for (int c = 0; c < 16; c++) begin
         for (int w = 0; w < 2; w++) begin
            for (int k = 0; k < 6; k++) begin
               run_op(4'(c), w[0],
                  {32'h7fffffff, 32'h00010000, 32'h80000000, 32'hffff7fff},
                  {32'hffff8000, 32'h00007fff, 32'hffffffff, 32'h00000005},
                  imms[k]);
            end
         end
      end
      repeat (300) begin
         r = $random(seed);
         run_op(r[3:0], r[4], rnd128(), rnd128(), r[15:8]);
      end
      spue_issue_model_inst.idle();
      @(negedge core_clk);
      chk_bit(res_valid_q, 1'b0);
      chk_vec(res_vec_q, vexp);
      rst_b = 1'b0;
      @(negedge core_clk);
      vexp = '0;
      gexp = '0;
      chk_gpr(res_gpr_q, gexp);
      rst_b = 1'b1;
      run_op(4'h0, 1'b1, rnd128(), rnd128(), 8'h00);
      results();
   end
endmodule : spue_top_test
`default_nettype wire
